/* rtl/fast_port.sv */
// Purpose: One fast SFR port: value, source select, synchronised pin state
// Assumes: Pin levels are asynchronous to clk_in
// Notes:   Pin state updates only once sync stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module fast_port
  import xdata_sfr_pkg::*;
#(
  parameter byte_t VALUE_ADDR  = 8'h00,
  parameter byte_t SOURCE_ADDR = 8'h00
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  port_sfr_if.slave         bus,
  input  wire logic [7:0]   hub_value_in,
  input  wire logic [7:0]   pin_level_in,
  output logic      [7:0]   drive_out,
  output logic      [7:0]   value_out,
  output logic      [7:0]   source_out,
  output logic      [7:0]   pin_state_out
);
  typedef struct packed {
    byte_t value;
    byte_t source;
    byte_t s1;
    byte_t s2;
    byte_t s3;
    byte_t state;
    byte_t drive;
  } fp_state_t;

  localparam fp_state_t FP_RESET = '{BYTE_RESET, BYTE_RESET, BYTE_RESET, BYTE_RESET,
                                     BYTE_RESET, BYTE_RESET, BYTE_RESET};

  fp_state_t st_r;
  fp_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (bus.wr && bus.addr == VALUE_ADDR) begin
      st_nxt.value = bus.wdata;
    end
    if (bus.wr && bus.addr == SOURCE_ADDR) begin
      st_nxt.source = bus.wdata;
    end
    st_nxt.s1 = pin_level_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 8; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.state[i] = st_r.s3[i];
      end
    end
    st_nxt.drive = (st_r.source & st_r.value) | (~st_r.source & hub_value_in);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_r <= FP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign drive_out     = st_r.drive;
  assign value_out     = st_r.value;
  assign source_out    = st_r.source;
  assign pin_state_out = st_r.state;
endmodule // fast_port
`default_nettype wire

/* rtl/port_sfr_if.sv */
// Purpose: SFR write path from the top to the fast port slices
// Assumes: One write strobe per cycle
// Notes:   Readback goes over plain ports of each slice
`timescale 1ns/1ns
`default_nettype none
interface port_sfr_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  modport master (output addr, output wdata, output wr);
  modport slave  (input addr, input wdata, input wr);
endinterface
`default_nettype wire

/* rtl/xdata_region_decode.sv */
// Purpose: Classify a 24-bit external-data address into regions
// Assumes: Caller registers the flags
// Notes:   Everything not SRAM, ECC or off-chip counts as on-chip peripheral
`timescale 1ns/1ns
`default_nettype none
module xdata_region_decode
  import xdata_sfr_pkg::*;
(
  input  wire xaddr_t addr_in,
  output logic        sram_out,
  output logic        ecc_out,
  output logic        ext_out,
  output logic        periph_out
);
  assign sram_out   = (addr_in <= SRAM_LAST);
  assign ecc_out    = (addr_in >= ECC_FIRST) && (addr_in <= ECC_LAST);
  assign ext_out    = (addr_in >= EXT_FIRST);
  assign periph_out = !sram_out && !ecc_out && !ext_out;
endmodule // xdata_region_decode
`default_nettype wire

/* rtl/xdata_sfr_pkg.sv */
// Purpose: Constants and types for the xdata address and fast port SFR block
// Assumes: Single core clock, synchronous active-low reset
// Notes:   Port slot order is 0,1,2,3,4,5,6,12,15
//
// How it works
// - Pointer-select bit 0 picks which data pointer every pointer instruction uses.
// - Extension bytes join the address only for external-data moves.
// - Pointer moves take the top byte from that pointer's high extension.
// - Index moves take top byte from move-extension, next from page-extension.
// - Value, select and pin-state registers exist for ports 0-6, 12, 15.
// - Select bit one drives the pin from the fast output value bit.
// - Select bit zero drives the pin from the hub port value bit.
// - Pin-state register is read-only, shows pin levels, writes ignored.
// - External-data space is 24 bits wide, 16 MB.
// - SRAM decodes up to 0x001FFF; flash ECC bytes start at 0x080000.
// - Addresses from 0x800000 upward go to the external memory interface.
package xdata_sfr_pkg;

  // ==========================================================
  // Types
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] ptr_t;
  typedef logic [23:0] xaddr_t;

  localparam int NUM_PORTS = 9;
  typedef logic [NUM_PORTS-1:0][7:0] port_bytes_t;

  // ==========================================================
  // Core SFR addresses
  localparam byte_t ADDR_PTR0_LO   = 8'h82;
  localparam byte_t ADDR_PTR0_HI   = 8'h83;
  localparam byte_t ADDR_PTR1_LO   = 8'h84;
  localparam byte_t ADDR_PTR1_HI   = 8'h85;
  localparam byte_t ADDR_PTR_SEL   = 8'h86;
  localparam byte_t ADDR_PTR0_EXT  = 8'h93;
  localparam byte_t ADDR_PTR1_EXT  = 8'h95;
  localparam byte_t ADDR_IDX_TOP   = 8'hEA;
  localparam byte_t ADDR_IDX_PAGE  = 8'hA0;

  // ==========================================================
  // Fast port SFR addresses, slot 8 first
  localparam port_bytes_t PORT_VALUE_ADDR =
    {8'hF8, 8'hE8, 8'hD8, 8'hC8, 8'hC0, 8'hB0, 8'h98, 8'h90, 8'h80};
  localparam port_bytes_t PORT_STATE_ADDR =
    {8'hF9, 8'hE9, 8'hD9, 8'hC9, 8'hC1, 8'hB1, 8'h99, 8'h91, 8'h89};
  localparam port_bytes_t PORT_SOURCE_ADDR =
    {8'hFA, 8'hF2, 8'hDA, 8'hCA, 8'hC2, 8'hB2, 8'h9A, 8'hA2, 8'h8A};

  // ==========================================================
  // Field positions and reset values
  localparam int    PTR_SEL_BIT = 0;
  localparam byte_t BYTE_RESET  = 8'h00;
  localparam ptr_t  PTR_RESET   = 16'h0000;
  localparam byte_t UNMAPPED_RD = 8'h00;

  // ==========================================================
  // Region bounds
  localparam xaddr_t SRAM_LAST  = 24'h001FFF;
  localparam xaddr_t ECC_FIRST  = 24'h080000;
  localparam xaddr_t ECC_LAST   = 24'h081FFF;
  localparam xaddr_t EXT_FIRST  = 24'h800000;

endpackage

/* rtl/xdata_sfr_top.sv */
// Purpose: Data pointers, external-data address forming, fast port SFRs
// Assumes: Core issues at most one pointer or move request per cycle
// Notes:   SFR reads answer one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module xdata_sfr_top (
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  input  wire logic [7:0]                 sfr_addr_in,
  input  wire logic                       sfr_wr_in,
  input  wire logic [7:0]                 sfr_wdata_in,
  input  wire logic                       sfr_rd_in,
  output logic      [7:0]                 sfr_rdata_out,
  output logic                            sfr_rvalid_out,
  output logic                            sfr_hit_out,
  input  wire logic                       ptr_inc_in,
  input  wire logic                       ptr_load_in,
  input  wire logic [15:0]                ptr_load_value_in,
  output logic      [15:0]                ptr_out,
  input  wire logic                       xmove_in,
  input  wire logic                       xmove_index_mode_in,
  input  wire logic [7:0]                 xmove_index_in,
  output xdata_sfr_pkg::xaddr_t           xaddr_out,
  output logic                            xaddr_valid_out,
  output logic                            region_sram_out,
  output logic                            region_ecc_out,
  output logic                            region_ext_out,
  output logic                            region_periph_out,
  input  wire xdata_sfr_pkg::port_bytes_t hub_port_value_in,
  input  wire xdata_sfr_pkg::port_bytes_t pin_level_in,
  output xdata_sfr_pkg::port_bytes_t      port_drive_out
);
  import xdata_sfr_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    ptr_t   ptr0;
    ptr_t   ptr1;
    byte_t  ptr_sel;
    byte_t  ptr0_ext;
    byte_t  ptr1_ext;
    byte_t  idx_top;
    byte_t  idx_page;
    ptr_t   ptr_cur;
    xaddr_t xaddr;
    logic   xvalid;
    logic   r_sram;
    logic   r_ecc;
    logic   r_ext;
    logic   r_periph;
    byte_t  rdata;
    logic   rvalid;
    logic   hit;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    ptr0:     PTR_RESET,
    ptr1:     PTR_RESET,
    ptr_sel:  BYTE_RESET,
    ptr0_ext: BYTE_RESET,
    ptr1_ext: BYTE_RESET,
    idx_top:  BYTE_RESET,
    idx_page: BYTE_RESET,
    ptr_cur:  PTR_RESET,
    xaddr:    24'h000000,
    xvalid:   1'b0,
    r_sram:   1'b0,
    r_ecc:    1'b0,
    r_ext:    1'b0,
    r_periph: 1'b0,
    rdata:    BYTE_RESET,
    rvalid:   1'b0,
    hit:      1'b0
  };

  top_state_t st_r;
  top_state_t st_nxt;

  // ==========================================================
  // Port slices
  port_sfr_if  port_bus ();
  port_bytes_t port_value;
  port_bytes_t port_source;
  port_bytes_t port_state;

  assign port_bus.addr  = sfr_addr_in;
  assign port_bus.wdata = sfr_wdata_in;
  assign port_bus.wr    = sfr_wr_in;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      fast_port #(
        .VALUE_ADDR  (PORT_VALUE_ADDR[g]),
        .SOURCE_ADDR (PORT_SOURCE_ADDR[g])
      ) u_port (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .bus           (port_bus.slave),
        .hub_value_in  (hub_port_value_in[g]),
        .pin_level_in  (pin_level_in[g]),
        .drive_out     (port_drive_out[g]),
        .value_out     (port_value[g]),
        .source_out    (port_source[g]),
        .pin_state_out (port_state[g])
      );
    end
  endgenerate

  // ==========================================================
  // Address forming
  logic   use_ptr1;
  ptr_t   sel_ptr;
  byte_t  sel_ext;
  xaddr_t move_addr;
  logic   dec_sram;
  logic   dec_ecc;
  logic   dec_ext;
  logic   dec_periph;

  // ==========================================================
  // Pointer select
  // selector bit picks pointer
  assign use_ptr1 = st_r.ptr_sel[PTR_SEL_BIT];
  assign sel_ptr  = use_ptr1 ? st_r.ptr1 : st_r.ptr0;
  assign sel_ext  = use_ptr1 ? st_r.ptr1_ext : st_r.ptr0_ext;

  // ==========================================================
  // Move address
  always_comb begin
    if (xmove_index_mode_in) begin
      move_addr = {st_r.idx_top, st_r.idx_page, xmove_index_in};
    end else begin
      move_addr = {sel_ext, sel_ptr};
    end
  end

  // ==========================================================
  // Region decode
  // Flags are registered with the address in the next-state logic
  xdata_region_decode u_decode (
    .addr_in    (move_addr),
    .sram_out   (dec_sram),
    .ecc_out    (dec_ecc),
    .ext_out    (dec_ext),
    .periph_out (dec_periph)
  );

  // ==========================================================
  // Port address match
  logic [NUM_PORTS-1:0] hit_value;
  logic [NUM_PORTS-1:0] hit_source;
  logic [NUM_PORTS-1:0] hit_state;
  logic                 port_hit;
  byte_t                port_rd;

  // Port addresses are all distinct, so at most one bit is set
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      hit_value[i]  = (sfr_addr_in == PORT_VALUE_ADDR[i]);
      hit_source[i] = (sfr_addr_in == PORT_SOURCE_ADDR[i]);
      hit_state[i]  = (sfr_addr_in == PORT_STATE_ADDR[i]);
    end
  end

  assign port_hit = |{hit_value, hit_source, hit_state};

  // OR of masked bytes keeps the 27-way select shallow
  always_comb begin
    port_rd = 8'h00;
    for (int i = 0; i < NUM_PORTS; i++) begin
      port_rd = port_rd | (port_value[i] & {8{hit_value[i]}});
      port_rd = port_rd | (port_source[i] & {8{hit_source[i]}});
      port_rd = port_rd | (port_state[i] & {8{hit_state[i]}});
    end
  end

  // ==========================================================
  // Read mux
  byte_t rd_value;
  logic  rd_hit;

  always_comb begin
    rd_value = UNMAPPED_RD;
    rd_hit   = 1'b1;
    case (sfr_addr_in)
      ADDR_PTR0_LO:  rd_value = st_r.ptr0[7:0];
      ADDR_PTR0_HI:  rd_value = st_r.ptr0[15:8];
      ADDR_PTR1_LO:  rd_value = st_r.ptr1[7:0];
      ADDR_PTR1_HI:  rd_value = st_r.ptr1[15:8];
      ADDR_PTR_SEL:  rd_value = st_r.ptr_sel;
      ADDR_PTR0_EXT: rd_value = st_r.ptr0_ext;
      ADDR_PTR1_EXT: rd_value = st_r.ptr1_ext;
      ADDR_IDX_TOP:  rd_value = st_r.idx_top;
      ADDR_IDX_PAGE: rd_value = st_r.idx_page;
      default:       rd_hit   = 1'b0;
    endcase
    // Port map and core map never overlap, so order is free
    if (port_hit) begin
      rd_value = port_rd;
      rd_hit   = 1'b1;
    end
  end

  // ==========================================================
  // Pointer instruction update
  logic ptr_upd_en;
  ptr_t ptr_upd;

  // load beats increment, both act on the selected pointer
  always_comb begin
    ptr_upd_en = ptr_load_in || ptr_inc_in;
    if (ptr_load_in) begin
      ptr_upd = ptr_load_value_in;
    end else begin
      // Plain 16-bit wrap, no carry into the extension byte
      ptr_upd = sel_ptr + 16'h0001;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = sfr_rd_in;
    st_nxt.xvalid = 1'b0;
    // Read data and hit hold until the next read strobe
    if (sfr_rd_in) begin
      st_nxt.rdata = rd_value;
      st_nxt.hit   = rd_hit;
    end

    // Register writes; pin-state addresses have no storage here
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        ADDR_PTR0_LO:  st_nxt.ptr0[7:0]  = sfr_wdata_in;
        ADDR_PTR0_HI:  st_nxt.ptr0[15:8] = sfr_wdata_in;
        ADDR_PTR1_LO:  st_nxt.ptr1[7:0]  = sfr_wdata_in;
        ADDR_PTR1_HI:  st_nxt.ptr1[15:8] = sfr_wdata_in;
        ADDR_PTR_SEL:  st_nxt.ptr_sel    = sfr_wdata_in;
        ADDR_PTR0_EXT: st_nxt.ptr0_ext   = sfr_wdata_in;
        ADDR_PTR1_EXT: st_nxt.ptr1_ext   = sfr_wdata_in;
        ADDR_IDX_TOP:  st_nxt.idx_top    = sfr_wdata_in;
        ADDR_IDX_PAGE: st_nxt.idx_page   = sfr_wdata_in;
        default: ;
      endcase
    end

    // Instruction updates win over an SFR write in the same cycle
    // increment and load hit selected pointer
    if (ptr_upd_en) begin
      if (use_ptr1) begin
        st_nxt.ptr1 = ptr_upd;
      end else begin
        st_nxt.ptr0 = ptr_upd;
      end
    end

    // plain 16-bit pointer for code reads and jumps
    st_nxt.ptr_cur = use_ptr1 ? st_nxt.ptr1 : st_nxt.ptr0;

    if (xmove_in) begin
      st_nxt.xaddr    = move_addr;
      st_nxt.xvalid   = 1'b1;
      // Region flags travel with the address they describe
      st_nxt.r_sram   = dec_sram;
      st_nxt.r_ecc    = dec_ecc;
      st_nxt.r_ext    = dec_ext;
      st_nxt.r_periph = dec_periph;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_r <= TOP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // All outputs come straight from flops, no decode glitches
  assign sfr_rdata_out     = st_r.rdata;
  assign sfr_rvalid_out    = st_r.rvalid;
  assign sfr_hit_out       = st_r.hit;
  assign ptr_out           = st_r.ptr_cur;
  assign xaddr_out         = st_r.xaddr;
  assign xaddr_valid_out   = st_r.xvalid;
  assign region_sram_out   = st_r.r_sram;
  assign region_ecc_out    = st_r.r_ecc;
  assign region_ext_out    = st_r.r_ext;
  assign region_periph_out = st_r.r_periph;

endmodule // xdata_sfr_top
`default_nettype wire

/* tb/pad_model.sv */
// Purpose: Pads seen by the fast ports
// Assumes: Pins follow their own drive unless a slot is overdriven
// Notes:   Overdrive stands for an outside part fighting the buffer
`timescale 1ns/1ns
`default_nettype none
module pad_model
  import xdata_sfr_pkg::*;
(
  input  wire port_bytes_t drive_in,
  input  wire logic [8:0]  ext_en_in,
  input  wire port_bytes_t ext_level_in,
  output port_bytes_t      level_out
);
  // ==========================================================
  // Pad levels
  always_comb begin
    for (int s = 0; s < NUM_PORTS; s++) begin
      level_out[s] = ext_en_in[s] ? ext_level_in[s] : drive_in[s];
    end
  end
endmodule // pad_model
`default_nettype wire

/* tb/xdata_address_and_port_sfr_tb_top.sv */
// Purpose: Directed bench for address forming and fast port SFRs
// Assumes: Core requests spaced by idle cycles
// Notes:   Pin state reads wait out the three-stage sync
`timescale 1ns/1ns
`default_nettype none
module xdata_address_and_port_sfr_tb_top;
  import xdata_sfr_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, xmove_index_in = 8'h00;
  logic ptr_inc_in = 1'b0, ptr_load_in = 1'b0, xmove_in = 1'b0, xmove_index_mode_in = 1'b0;
  logic [15:0] ptr_load_value_in = 16'h0000;
  logic [7:0] sfr_rdata_out;
  logic sfr_rvalid_out, sfr_hit_out, xaddr_valid_out;
  logic region_sram_out, region_ecc_out, region_ext_out, region_periph_out;
  logic [15:0] ptr_out;
  xaddr_t xaddr_out;
  port_bytes_t hub_port_value_in = '0, pin_level, port_drive_out, ext_level = '0;
  logic [8:0] ext_en = 9'h008;
  int mismatches = 0, check_count = 0, cycles = 0;
  byte_t core_addrs [9] = '{ADDR_PTR0_LO, ADDR_PTR0_HI, ADDR_PTR1_LO, ADDR_PTR1_HI,
    ADDR_PTR_SEL, ADDR_PTR0_EXT, ADDR_PTR1_EXT, ADDR_IDX_TOP, ADDR_IDX_PAGE};
  xaddr_t moves [8] = '{24'h001FFF, 24'h002000, 24'h080000, 24'h081FFF,
    24'h082000, 24'h7FFFFF, 24'h800000, 24'hFFFFFF};
  xdata_sfr_top i_dut (.clk_in, .resetn_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
    .sfr_rd_in, .sfr_rdata_out, .sfr_rvalid_out, .sfr_hit_out, .ptr_inc_in, .ptr_load_in,
    .ptr_load_value_in, .ptr_out, .xmove_in, .xmove_index_mode_in, .xmove_index_in,
    .xaddr_out, .xaddr_valid_out, .region_sram_out, .region_ecc_out, .region_ext_out,
    .region_periph_out, .hub_port_value_in, .pin_level_in(pin_level), .port_drive_out);
  pad_model i_pads (.drive_in(port_drive_out), .ext_en_in(ext_en),
    .ext_level_in(ext_level), .level_out(pin_level));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic sfr_write(input byte_t a, input byte_t d);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic sfr_read(input byte_t a, input byte_t exp, input logic hit);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    #1;
    chk(sfr_rvalid_out, 1'b1, "read valid");
    chk(sfr_rdata_out, exp, "read data");
    chk(sfr_hit_out, hit, "read hit");
  endtask
  task automatic ptr_cmd(input logic load, input logic [15:0] v);
    @(posedge clk_in);
    ptr_load_in <= load;
    ptr_inc_in <= !load;
    ptr_load_value_in <= v;
    @(posedge clk_in);
    ptr_load_in <= 1'b0;
    ptr_inc_in <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  function automatic logic [3:0] region_of(input xaddr_t a);
    if (a <= 24'h001FFF) return 4'h8;
    if (a >= 24'h080000 && a <= 24'h081FFF) return 4'h4;
    return (a >= 24'h800000) ? 4'h2 : 4'h1;
  endfunction
  task automatic xmove(input logic idx_mode, input byte_t idx, input xaddr_t exp);
    @(posedge clk_in);
    xmove_in <= 1'b1;
    xmove_index_mode_in <= idx_mode;
    xmove_index_in <= idx;
    @(posedge clk_in);
    xmove_in <= 1'b0;
    #1;
    chk(xaddr_valid_out, 1'b1, "move valid");
    chk(xaddr_out, exp, "move address");
    chk({region_sram_out, region_ecc_out, region_ext_out, region_periph_out},
      region_of(exp), "regions");
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    ext_level[3] <= 8'h3C;
    for (int s = 0; s < NUM_PORTS; s++) hub_port_value_in[s] <= {s[3:0], 4'h6};
    repeat (4) @(posedge clk_in);
    foreach (core_addrs[i]) sfr_read(core_addrs[i], 8'h00, 1'b1);
    sfr_read(8'hB8, 8'h00, 1'b0);
    sfr_read(8'h8B, 8'h00, 1'b0);
    for (int s = 0; s < NUM_PORTS; s++) begin
      sfr_read(PORT_SOURCE_ADDR[s], 8'h00, 1'b1);
      sfr_write(PORT_VALUE_ADDR[s], 8'hA5);
      sfr_write(PORT_SOURCE_ADDR[s], 8'h0F);
    end
    repeat (6) @(posedge clk_in);
    #1;
    // Low nibble fast value, high nibble hub value
    for (int s = 0; s < NUM_PORTS; s++) chk(port_drive_out[s], {s[3:0], 4'h5}, "drive");
    for (int s = 0; s < NUM_PORTS; s++) begin
      sfr_read(PORT_VALUE_ADDR[s], 8'hA5, 1'b1);
      sfr_read(PORT_STATE_ADDR[s], (s == 3) ? 8'h3C : {s[3:0], 4'h5}, 1'b1);
    end
    sfr_write(PORT_STATE_ADDR[3], 8'hFF);
    ext_level[3] <= 8'hC3;
    repeat (6) @(posedge clk_in);
    sfr_read(PORT_STATE_ADDR[3], 8'hC3, 1'b1);
    sfr_write(ADDR_PTR0_LO, 8'h34);
    sfr_write(ADDR_PTR0_HI, 8'h12);
    sfr_write(ADDR_PTR0_EXT, 8'h80);
    xmove(1'b0, 8'h00, 24'h801234);
    sfr_write(ADDR_PTR1_LO, 8'h10);
    sfr_write(ADDR_PTR_SEL, 8'h01);
    sfr_read(ADDR_PTR_SEL, 8'h01, 1'b1);
    xmove(1'b0, 8'h00, 24'h000010);
    ptr_cmd(1'b0, 16'h0000);
    chk(ptr_out, 16'h0011, "inc");
    sfr_read(ADDR_PTR1_LO, 8'h11, 1'b1);
    sfr_read(ADDR_PTR0_LO, 8'h34, 1'b1);
    ptr_cmd(1'b1, 16'hFFFF);
    ptr_cmd(1'b0, 16'h0000);
    chk(ptr_out, 16'h0000, "wrap");
    sfr_write(ADDR_PTR_SEL, 8'h00);
    repeat (2) @(posedge clk_in);
    #1;
    chk(ptr_out, 16'h1234, "select back");
    // Pointer extension stays out of index moves
    foreach (moves[i]) begin
      sfr_write(ADDR_IDX_TOP, moves[i][23:16]);
      sfr_write(ADDR_IDX_PAGE, moves[i][15:8]);
      xmove(1'b1, moves[i][7:0], moves[i]);
    end
    give_verdict();
  end
endmodule // xdata_address_and_port_sfr_tb_top
`default_nettype wire

/* tb/xdata_sfr_sva.sv */
// Purpose: Port-level checks of the address and port block
// Assumes: One clock, synchronous active-low reset
// Notes:   Increment check skips cycles that follow a pointer-select SFR write
`timescale 1ns/1ns
`default_nettype none
module xdata_sfr_sva
  import xdata_sfr_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [7:0]  sfr_addr_in,
  input wire logic        sfr_wr_in,
  input wire logic        sfr_rd_in,
  input wire logic [7:0]  sfr_rdata_out,
  input wire logic        sfr_rvalid_out,
  input wire logic        sfr_hit_out,
  input wire logic        ptr_inc_in,
  input wire logic        ptr_load_in,
  input wire logic [15:0] ptr_load_value_in,
  input wire logic [15:0] ptr_out,
  input wire logic        xmove_in,
  input wire logic        xmove_index_mode_in,
  input wire logic [7:0]  xmove_index_in,
  input wire xaddr_t      xaddr_out,
  input wire logic        xaddr_valid_out,
  input wire logic        region_sram_out,
  input wire logic        region_ecc_out,
  input wire logic        region_ext_out,
  input wire logic        region_periph_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================================
  // Assertions
  read_answer_a: assert property (sfr_rd_in |=> sfr_rvalid_out)
    else $error("read strobe not answered");
  read_quiet_a: assert property (!sfr_rd_in |=> !sfr_rvalid_out)
    else $error("answer without a read");
  unmapped_zero_a: assert property (sfr_rvalid_out && !sfr_hit_out |-> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  move_valid_a: assert property (1'b1 |=> xaddr_valid_out == $past(xmove_in))
    else $error("move valid pulse wrong");
  move_hold_a: assert property (!xmove_in |=> $stable(xaddr_out))
    else $error("address changed without move");
  index_low_a: assert property (xmove_in && xmove_index_mode_in
    |=> xaddr_out[7:0] == $past(xmove_index_in))
    else $error("index low byte wrong");
  sram_decode_a: assert property (xaddr_valid_out |-> region_sram_out == (xaddr_out <= SRAM_LAST))
    else $error("sram decode wrong");
  ecc_decode_a: assert property (xaddr_valid_out |-> region_ecc_out ==
    (xaddr_out >= ECC_FIRST && xaddr_out <= ECC_LAST))
    else $error("ecc decode wrong");
  ext_decode_a: assert property (xaddr_valid_out |-> region_ext_out == (xaddr_out >= EXT_FIRST))
    else $error("off-chip decode wrong");
  region_single_a: assert property (xaddr_valid_out |-> $onehot({region_sram_out,
    region_ecc_out, region_ext_out, region_periph_out}))
    else $error("region flags not one-hot");
  ptr_load_a: assert property (ptr_load_in |=> ptr_out == $past(ptr_load_value_in))
    else $error("pointer load wrong");
  ptr_inc_a: assert property (ptr_inc_in && !ptr_load_in
    && !$past(sfr_wr_in && sfr_addr_in == ADDR_PTR_SEL)
    |=> ptr_out == $past(ptr_out) + 16'h0001)
    else $error("pointer increment wrong");
endmodule // xdata_sfr_sva
bind xdata_sfr_top xdata_sfr_sva i_sva (.clk_in, .resetn_in, .sfr_addr_in, .sfr_wr_in,
  .sfr_rd_in, .sfr_rdata_out,
  .sfr_rvalid_out, .sfr_hit_out, .ptr_inc_in, .ptr_load_in, .ptr_load_value_in, .ptr_out,
  .xmove_in, .xmove_index_mode_in, .xmove_index_in, .xaddr_out, .xaddr_valid_out,
  .region_sram_out, .region_ecc_out, .region_ext_out, .region_periph_out);
`default_nettype wire
